//--- yovp_pkg.sv
package yovp_pkg;
   // Register map: config word indices (byte address is four times the index), then status byte offsets
   localparam int          CFG_WORDS      = 12;
   localparam logic [3:0]  IDX_CTRL       = 4'h0;
   localparam logic [3:0]  IDX_LINE_SKIP  = 4'h1;
   localparam logic [3:0]  IDX_PIXEL_SKIP = 4'h2;
   localparam logic [3:0]  IDX_BASE       = 4'h3;
   localparam logic [3:0]  IDX_SRC        = 4'h4;
   localparam logic [3:0]  IDX_WIN        = 4'h5;
   localparam logic [3:0]  IDX_SCALE      = 4'h6;
   localparam logic [3:0]  IDX_CSC_OFF    = 4'h7;
   localparam int          IDX_CSC_ROW0   = 8;
   localparam logic [3:0]  IDX_CURSOR     = 4'hB;
   localparam logic [7:0]  OFS_STATUS     = 8'h30;
   localparam logic [7:0]  OFS_FETCH      = 8'h34;
   localparam logic [7:0]  OFS_SCALE_POS  = 8'h38;
   localparam logic [31:0] CFG_RST        = 32'h0000_0000;
   localparam logic [CFG_WORDS-1:0][31:0] CFG_MASK = {
      32'h007F_7F07, 32'h3FFF_FFFF, 32'h3FFF_FFFF, 32'h3FFF_FFFF,
      32'h00FF_FFFF, 32'hFFFF_FFFF, 32'h03FF_03FF, 32'h03FF_03FF,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_000F};
   // Field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_FMT420_BIT = 1;
   localparam int CTRL_RESIZE_BIT = 2;
   localparam int CTRL_PRIO_BIT   = 3;
   localparam int DIM_W           = 10;
   localparam int SIZE_W_LSB      = 0;
   localparam int SIZE_H_LSB      = 16;
   localparam int RATIO_W         = 16;
   localparam int RATIO_H_LSB     = 0;
   localparam int RATIO_V_LSB     = 16;
   localparam int COEF_W          = 10;
   localparam int COEF_FRAC       = 7;
   localparam int OFF_Y_LSB       = 0;
   localparam int OFF_CB_LSB      = 8;
   localparam int OFF_CR_LSB      = 16;
   localparam int CUR_BPP_LSB     = 0;
   localparam int CUR_W_LSB       = 8;
   localparam int CUR_H_LSB       = 16;
   localparam int CUR_DIM_W       = 7;
   localparam logic [2:0] CUR_BPP_MAX = 3'h6;
   // Datapath sizes
   localparam int          CACHE_DEPTH = 512;
   localparam int          IDX_W       = 9;
   localparam int          POS_W       = 26;
   localparam int          POS_FRAC    = 10;
   localparam logic [15:0] SCALE_UNITY = 16'h0400;
   localparam logic [31:0] PIX_BYTES   = 32'h0000_0001;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_LOAD = 3'h1, ST_EVEN = 3'h3,
      ST_ODD  = 3'h2, ST_NEXT = 3'h6
   } yovp_state_e;
   typedef enum logic [1:0] {
      LAYER_BASE = 2'h0, LAYER_VIDEO = 2'h1,
      LAYER_OVERLAY_LAYER_ONE = 2'h2, LAYER_CURSOR = 2'h3
   } yovp_layer_e;
   typedef struct packed { logic [7:0] cb; logic [7:0] cr; } yovp_pair_s;
   typedef struct packed {
      logic [7:0] r; logic [7:0] g; logic [7:0] b;
   } yovp_rgb_s;
   typedef struct packed {
      logic [2:0][2:0][COEF_W-1:0] coef;
      logic [7:0] y_off; logic [7:0] cb_off; logic [7:0] cr_off;
   } yovp_csc_s;
   typedef struct packed {
      yovp_layer_e top; yovp_layer_e second;
      yovp_layer_e third; yovp_layer_e bottom;
   } yovp_order_s;
   typedef struct packed {
      logic [2:0] bpp_code;
      logic [CUR_DIM_W-1:0] width_m1;
      logic [CUR_DIM_W-1:0] height_m1;
   } yovp_cursor_s;

   function automatic yovp_pair_s yovp_avg2(input yovp_pair_s a,
                                            input yovp_pair_s b);
      logic [8:0] s_cb;
      logic [8:0] s_cr;
      s_cb = {1'b0, a.cb} + {1'b0, b.cb};
      s_cr = {1'b0, a.cr} + {1'b0, b.cr};
      return '{cb: s_cb[8:1], cr: s_cr[8:1]};
   endfunction : yovp_avg2

   function automatic yovp_pair_s yovp_avg4(input yovp_pair_s a,
      input yovp_pair_s b, input yovp_pair_s c, input yovp_pair_s d);
      logic [9:0] s_cb;
      logic [9:0] s_cr;
      s_cb = {2'h0, a.cb} + {2'h0, b.cb} + {2'h0, c.cb} + {2'h0, d.cb};
      s_cr = {2'h0, a.cr} + {2'h0, b.cr} + {2'h0, c.cr} + {2'h0, d.cr};
      return '{cb: s_cb[9:2], cr: s_cr[9:2]};
   endfunction : yovp_avg4

   function automatic logic [31:0] yovp_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction : yovp_merge
endpackage : yovp_pkg

//--- yovp_csc.sv
`timescale 1ns/1ps
module yovp_csc (
   input  wire logic [7:0]          luma,
   input  wire yovp_pkg::yovp_pair_s chroma,
   input  wire yovp_pkg::yovp_csc_s  cfg,
   output yovp_pkg::yovp_rgb_s       rgb
);
   import yovp_pkg::*;

   // Coefficients are s2.7; products of a 9-bit offset input fit 21 bits
   function automatic logic [7:0] yovp_mac(
      input logic [2:0][COEF_W-1:0] row,
      input logic signed [8:0] dy, input logic signed [8:0] dcb,
      input logic signed [8:0] dcr);
      logic signed [20:0] acc;
      acc = $signed(row[0]) * dy + $signed(row[1]) * dcb
          + $signed(row[2]) * dcr;
      acc = acc >>> COEF_FRAC;
      if (acc < 0) return 8'h00;
      if (acc > 21'sd255) return 8'hFF;
      return acc[7:0];
   endfunction : yovp_mac

   logic signed [8:0] dy;
   logic signed [8:0] dcb;
   logic signed [8:0] dcr;

   assign dy  = $signed({1'b0, luma}) - $signed({1'b0, cfg.y_off});
   assign dcb = $signed({1'b0, chroma.cb}) - $signed({1'b0, cfg.cb_off});
   assign dcr = $signed({1'b0, chroma.cr}) - $signed({1'b0, cfg.cr_off});
   assign rgb.r = yovp_mac(cfg.coef[0], dy, dcb, dcr);
   assign rgb.g = yovp_mac(cfg.coef[1], dy, dcb, dcr);
   assign rgb.b = yovp_mac(cfg.coef[2], dy, dcb, dcr);
endmodule : yovp_csc

//--- yovp_stride.sv
`timescale 1ns/1ps
module yovp_stride (
   input  wire logic [31:0] addr,
   input  wire logic [31:0] pixel_skip_offset,
   input  wire logic [31:0] line_skip_offset,
   output logic [31:0]      after_pixel,
   output logic [31:0]      after_line
);
   import yovp_pkg::*;

   // Modulo-2^32 add is the two's-complement add, so negative skips step back
   assign after_pixel = addr + PIX_BYTES + pixel_skip_offset;
   assign after_line  = addr + line_skip_offset;
endmodule : yovp_stride

//--- yovp_top.sv
`timescale 1ns/1ps
module yovp_top (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output logic [1:0]                 s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   input  wire logic [7:0]            s_axi_araddr,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   input  wire logic                  luma_valid,
   output logic                       luma_ready,
   input  wire logic [31:0]           luma_data,
   input  wire logic                  chroma_valid,
   output logic                       chroma_ready,
   input  wire logic [31:0]           chroma_data,
   output logic                       pix_valid,
   input  wire logic                  pix_ready,
   output yovp_pkg::yovp_rgb_s        pix_rgb,
   output logic [31:0]                fetch_addr,
   output logic                       resize_active,
   output yovp_pkg::yovp_order_s      layer_order,
   output yovp_pkg::yovp_cursor_s     cursor_cfg
);
   import yovp_pkg::*;

   typedef struct packed {
      logic                          aw_got;
      logic [7:0]                    aw_addr;
      logic                          w_got;
      logic [31:0]                   w_data;
      logic [3:0]                    w_strb;
      logic                          bvalid;
      logic [1:0]                    bresp;
      logic                          rvalid;
      logic [31:0]                   rdata;
      logic [1:0]                    rresp;
      logic [CFG_WORDS-1:0][31:0]    cfg;
      yovp_state_e                   st;
      logic                          vert;
      logic                          cache_full;
      logic [DIM_W-1:0]              line;
      logic [IDX_W:0]                idx;
      logic                          half;
      logic [1:0]                    luma_sel;
      yovp_pair_s                    a_n;
      yovp_pair_s                    b_n;
      yovp_pair_s                    a_n1;
      yovp_pair_s                    b_n1;
      yovp_pair_s [CACHE_DEPTH-1:0]  cache;
      logic                          pix_valid;
      yovp_rgb_s                     pix_rgb;
      logic [31:0]                   addr;
      logic [POS_W-1:0]              sx;
      logic [POS_W-1:0]              sy;
   } yovp_top_s;

   yovp_top_s q;
   yovp_top_s next_q;

   logic [31:0]        ctrl;
   logic [31:0]        src;
   logic [31:0]        ratio;
   logic [31:0]        offs;
   logic [31:0]        cur_word;
   logic               enable;
   logic               fmt420;
   logic               resize;
   logic [DIM_W-1:0]   src_h_m1;
   logic [IDX_W-1:0]   cw_m1;
   logic [DIM_W-1:0]   ch_m1;
   logic               last_line;
   logic               tail;
   logic               use_cache;
   logic               need_ext;
   logic               take_c;
   logic               advance;
   logic               out_free;
   logic               go;
   yovp_pair_s         cur_pair;
   yovp_pair_s         cache_rd;
   yovp_pair_s         src_n;
   yovp_pair_s         src_n1;
   yovp_pair_s         even_c;
   yovp_pair_s         odd_c;
   yovp_pair_s         emit_c;
   logic [7:0]         luma_byte;
   yovp_rgb_s          rgb_w;
   yovp_csc_s          csc_cfg;
   logic [31:0]        after_pixel;
   logic [31:0]        after_line;
   logic [POS_W-1:0]   step_x;
   logic [POS_W-1:0]   step_y;
   logic [3:0]         w_idx;
   logic [3:0]         r_idx;

   assign ctrl      = q.cfg[IDX_CTRL];
   assign src       = q.cfg[IDX_SRC];
   assign ratio     = q.cfg[IDX_SCALE];
   assign offs      = q.cfg[IDX_CSC_OFF];
   assign cur_word  = q.cfg[IDX_CURSOR];
   assign enable    = ctrl[CTRL_ENABLE_BIT];
   assign fmt420    = ctrl[CTRL_FMT420_BIT];
   assign resize    = ctrl[CTRL_RESIZE_BIT];
   assign src_h_m1  = src[SIZE_H_LSB +: DIM_W];
   assign cw_m1     = src[SIZE_W_LSB + 1 +: IDX_W];
   assign ch_m1     = {1'b0, src[SIZE_H_LSB + 1 +: DIM_W - 1]};
   assign w_idx     = q.aw_addr[5:2];
   assign r_idx     = s_axi_araddr[5:2];

   // Chroma pair from the interleaved word, half 0 in the low bytes
   assign cur_pair  = q.half ? yovp_pair_s'{cb: chroma_data[31:24],
                                            cr: chroma_data[23:16]}
                             : yovp_pair_s'{cb: chroma_data[15:8],
                                            cr: chroma_data[7:0]};
   assign luma_byte = luma_data[{q.luma_sel, 3'h0} +: 8];
   assign cache_rd  = q.cache[q.idx[IDX_W-1:0]];

   // Past the last sample the held one is reused as its own neighbour
   assign tail      = q.idx > {1'b0, cw_m1};
   assign last_line = q.line == ch_m1;
   assign use_cache = fmt420 && q.cache_full;
   assign need_ext  = !tail && (!use_cache
                     || (q.vert && !last_line));
   assign src_n     = tail ? q.b_n : (use_cache ? cache_rd : cur_pair);
   // Final vertical pass has no line n+1, so line n stands in for it
   assign src_n1    = tail ? q.b_n1
                    : (last_line ? cache_rd : cur_pair);
   assign take_c    = (q.st == ST_LOAD) && need_ext && chroma_valid;
   assign advance   = !need_ext || chroma_valid;
   assign chroma_ready = (q.st == ST_LOAD) && need_ext && q.half;

   assign even_c = q.vert ? yovp_avg2(q.a_n, q.a_n1) : q.a_n;
   assign odd_c  = q.vert ? yovp_avg4(q.a_n, q.b_n, q.a_n1, q.b_n1)
                          : yovp_avg2(q.a_n, q.b_n);
   assign emit_c = (q.st == ST_ODD) ? odd_c : even_c;

   assign out_free   = !q.pix_valid || pix_ready;
   assign go         = luma_valid && out_free
                     && ((q.st == ST_EVEN) || (q.st == ST_ODD));
   assign luma_ready = go && (q.luma_sel == 2'h3);

   assign step_x = {10'h000, resize ? ratio[RATIO_H_LSB +: RATIO_W]
                                    : SCALE_UNITY};
   assign step_y = {10'h000, resize ? ratio[RATIO_V_LSB +: RATIO_W]
                                    : SCALE_UNITY};

   always_comb begin
      csc_cfg        = '0;
      csc_cfg.y_off  = offs[OFF_Y_LSB +: 8];
      csc_cfg.cb_off = offs[OFF_CB_LSB +: 8];
      csc_cfg.cr_off = offs[OFF_CR_LSB +: 8];
      for (int r = 0; r < 3; r++) begin
         for (int c = 0; c < 3; c++) begin
            csc_cfg.coef[r][c] =
               q.cfg[IDX_CSC_ROW0 + r][c*COEF_W +: COEF_W];
         end
      end
   end

   yovp_csc u_csc (
      .luma   (luma_byte),
      .chroma (emit_c),
      .cfg    (csc_cfg),
      .rgb    (rgb_w)
   );

   yovp_stride u_stride (
      .addr              (q.addr),
      .pixel_skip_offset (q.cfg[IDX_PIXEL_SKIP]),
      .line_skip_offset  (q.cfg[IDX_LINE_SKIP]),
      .after_pixel       (after_pixel),
      .after_line        (after_line)
   );

   always_comb begin
      next_q = q;
      // Address and data are captured independently, in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_q.aw_got  = 1'b1;
         next_q.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_q.w_got  = 1'b1;
         next_q.w_data = s_axi_wdata;
         next_q.w_strb = s_axi_wstrb;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         next_q.aw_got = 1'b0;
         next_q.w_got  = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp  = RESP_OKAY;
         if (q.aw_addr < OFS_STATUS) begin
            next_q.cfg[w_idx] = yovp_merge(q.cfg[w_idx], q.w_data,
                                           q.w_strb) & CFG_MASK[w_idx];
         end else if (q.aw_addr > OFS_SCALE_POS) begin
            next_q.bresp = RESP_SLVERR;
         end
      end else if (q.bvalid && s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end
      if (q.rvalid) begin
         if (s_axi_rready) begin
            next_q.rvalid = 1'b0;
         end
      end else if (s_axi_arvalid) begin
         next_q.rvalid = 1'b1;
         next_q.rresp  = RESP_OKAY;
         if (s_axi_araddr < OFS_STATUS) begin
            next_q.rdata = q.cfg[r_idx];
         end else begin
            case (s_axi_araddr)
               OFS_STATUS: begin
                  next_q.rdata = {6'h00, q.line, 11'h000,
                                  q.cache_full, q.vert, q.st};
               end
               OFS_FETCH: begin
                  next_q.rdata = q.addr;
               end
               OFS_SCALE_POS: begin
                  next_q.rdata = {q.sy[POS_W-1:POS_FRAC],
                                  q.sx[POS_W-1:POS_FRAC]};
               end
               default: begin
                  next_q.rdata = 32'h0000_0000;
                  next_q.rresp = RESP_SLVERR;
               end
            endcase
         end
      end

      if (take_c) begin
         next_q.half = !q.half;
         if (fmt420) begin
            next_q.cache[q.idx[IDX_W-1:0]] = cur_pair;
         end
      end

      case (q.st)
         ST_IDLE: begin
            next_q.line       = '0;
            next_q.vert       = 1'b0;
            next_q.cache_full = 1'b0;
            next_q.idx        = '0;
            next_q.half       = 1'b0;
            next_q.luma_sel   = 2'h0;
            next_q.addr       = q.cfg[IDX_BASE];
            next_q.sx         = '0;
            next_q.sy         = '0;
            if (enable) begin
               next_q.st = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (advance) begin
               // Sliding pair window: a is sample i, b is sample i+1
               next_q.a_n  = q.b_n;
               next_q.b_n  = src_n;
               next_q.a_n1 = q.b_n1;
               next_q.b_n1 = src_n1;
               if (q.idx == '0) begin
                  next_q.idx = q.idx + 10'h001;
               end else begin
                  next_q.st = ST_EVEN;
               end
            end
         end
         ST_EVEN: begin
            if (go) begin
               next_q.st = ST_ODD;
            end
         end
         ST_ODD: begin
            if (go) begin
               if (tail) begin
                  next_q.st = ST_NEXT;
               end else begin
                  next_q.idx = q.idx + 10'h001;
                  next_q.st  = ST_LOAD;
               end
            end
         end
         ST_NEXT: begin
            next_q.idx  = '0;
            next_q.sx   = '0;
            next_q.sy   = q.sy + step_y;
            next_q.addr = after_line;
            next_q.st   = enable ? ST_LOAD : ST_IDLE;
            if (fmt420 && !q.vert) begin
               next_q.vert       = 1'b1;
               next_q.cache_full = 1'b1;
            end else begin
               next_q.vert = 1'b0;
               if (fmt420 ? last_line : (q.line == src_h_m1)) begin
                  next_q.line       = '0;
                  next_q.cache_full = 1'b0;
                  next_q.addr       = q.cfg[IDX_BASE];
                  next_q.sy         = '0;
               end else begin
                  next_q.line = q.line + 10'h001;
               end
            end
         end
         default: begin
            next_q.st = ST_IDLE;
         end
      endcase

      // Output register drains even while the pipeline waits on luma
      if (go) begin
         next_q.pix_valid = 1'b1;
         next_q.pix_rgb   = rgb_w;
         next_q.luma_sel  = q.luma_sel + 2'h1;
         next_q.addr      = after_pixel;
         next_q.sx        = q.sx + step_x;
      end else if (pix_ready) begin
         next_q.pix_valid = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q     <= '0;
         q.cfg <= {CFG_WORDS{CFG_RST}};
         q.st  <= ST_IDLE;
      end else begin
         q <= next_q;
      end
   end

   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready  = !q.w_got && !q.bvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign pix_valid     = q.pix_valid;
   assign pix_rgb       = q.pix_rgb;
   assign fetch_addr    = q.addr;
   assign resize_active = resize;

   assign layer_order = ctrl[CTRL_PRIO_BIT]
      ? yovp_order_s'{top: LAYER_CURSOR, second: LAYER_VIDEO,
          third: LAYER_OVERLAY_LAYER_ONE, bottom: LAYER_BASE}
      : yovp_order_s'{top: LAYER_CURSOR, second: LAYER_OVERLAY_LAYER_ONE,
          third: LAYER_VIDEO, bottom: LAYER_BASE};

   // Unsupported depth codes fold onto the deepest true-color mode
   assign cursor_cfg.bpp_code  =
      (cur_word[CUR_BPP_LSB +: 3] > CUR_BPP_MAX)
      ? CUR_BPP_MAX : cur_word[CUR_BPP_LSB +: 3];
   assign cursor_cfg.width_m1  = cur_word[CUR_W_LSB +: CUR_DIM_W];
   assign cursor_cfg.height_m1 = cur_word[CUR_H_LSB +: CUR_DIM_W];
endmodule : yovp_top

//--- yovp_top_asserts.sv
`timescale 1ns/1ps
module yovp_top_asserts (
   input wire logic clock, rst_n, s_axi_bvalid, s_axi_bready,
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic s_axi_rready, pix_valid, pix_ready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [31:0] s_axi_rdata,
   input wire yovp_pkg::yovp_rgb_s    pix_rgb,
   input wire yovp_pkg::yovp_order_s  layer_order,
   input wire yovp_pkg::yovp_cursor_s cursor_cfg
);
   import yovp_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read late");
   a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read overlap");
   a_pixel_held: assert property (pix_valid && !pix_ready |=>
      pix_valid && $stable(pix_rgb)) else $error("pixel lost");
   a_order_ends: assert property (layer_order.top == LAYER_CURSOR &&
      layer_order.bottom == LAYER_BASE) else $error("order ends");
   a_order_mid: assert property (layer_order.second !=
      layer_order.third && layer_order.third inside {LAYER_VIDEO,
      LAYER_OVERLAY_LAYER_ONE}) else $error("order middle");
   a_cursor_depth: assert property (cursor_cfg.bpp_code <= CUR_BPP_MAX)
      else $error("cursor depth");
   c_pixel: cover property (pix_valid && pix_ready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_swap: cover property (layer_order.second == LAYER_VIDEO);
endmodule : yovp_top_asserts
bind yovp_top yovp_top_asserts i_yovp_top_asserts (.clock, .rst_n,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .pix_valid, .pix_ready, .s_axi_bresp,
   .s_axi_rdata, .pix_rgb, .layer_order, .cursor_cfg);

//--- yovp_mem_model.sv
`timescale 1ns/1ps
module yovp_mem_model (
   input wire logic clock, rst_n, slow, luma_ready, chroma_ready,
   input wire logic [31:0] luma_word, chroma_word,
   output logic            luma_valid, chroma_valid,
   output logic [31:0]     luma_data, chroma_data
);
   logic gap;
   // Idle words read inverted, so stale data never looks fresh
   assign luma_data = luma_valid ? luma_word : ~luma_word;
   assign chroma_data = chroma_valid ? chroma_word : ~chroma_word;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gap <= 1'b0;
         luma_valid <= 1'b0;
         chroma_valid <= 1'b0;
      end else begin
         gap <= ~gap;
         if (!luma_valid || luma_ready) luma_valid <= !slow || gap;
         if (!chroma_valid || chroma_ready) chroma_valid <= !slow || gap;
      end
   end
endmodule : yovp_mem_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   import yovp_pkg::*;
   logic clock = 0, rst_n = 0, pix_ready = 0, slow = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, y;
   logic [31:0] s_axi_wdata = 0, lw, cw, s_axi_rdata, luma_data, chroma_data;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, luma_valid, luma_ready, chroma_valid, chroma_ready;
   logic pix_valid, resize_active;
   logic [31:0] fetch_addr;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [8:0] sb, sr;
   yovp_rgb_s pix_rgb;
   yovp_order_s layer_order;
   yovp_cursor_s cursor_cfg;
   logic [33:0] bq[$], pq[$], aq[$];
   int err_count = 0, n_tests = 0, cyc = 0;
   always #5 clock = ~clock;
   always @(posedge clock) begin
      pix_ready <= 1'($urandom);
      slow <= 1'($urandom);
   end
   yovp_top i_yovp_top (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .luma_valid, .luma_ready,
      .luma_data, .chroma_valid, .chroma_ready, .chroma_data, .pix_valid,
      .pix_ready, .pix_rgb, .fetch_addr, .resize_active, .layer_order,
      .cursor_cfg);
   yovp_mem_model i_yovp_mem_model (.clock, .rst_n, .slow, .luma_ready,
      .chroma_ready, .luma_word(lw), .chroma_word(cw), .luma_valid,
      .chroma_valid, .luma_data, .chroma_data);
   task automatic cmp(input logic [33:0] g, input logic [33:0] x);
      n_tests++;
      if (g !== x) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : cmp
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [1:0] e);
      logic [2:0] p;
      @(posedge clock);
      p = w ? 3'b111 : 3'b101;
      bq.push_back({e, w ? 32'h0 : d});
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      forever begin
         if (w) {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
         else {s_axi_arvalid, s_axi_rready} <= {p[2], p[0]};
         if (p == 0) break;
         @(negedge clock);
         p &= w ? ~{s_axi_awready, s_axi_wready, s_axi_bvalid}
                : ~{s_axi_arready, 1'b0, s_axi_rvalid};
         @(posedge clock);
      end
   endtask : xfer
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   // Sampled mid-cycle, so handshake values are settled
   always @(negedge clock) begin
      if (++cyc > 6000) begin
         err_count++;
         close_out();
      end else begin
         if (s_axi_bvalid && s_axi_bready)
            cmp({s_axi_bresp, 32'h0}, bq.pop_front());
         if (s_axi_rvalid && s_axi_rready)
            cmp({s_axi_rresp, s_axi_rdata}, bq.pop_front());
         if (pix_valid && pix_ready && pq.size() > 0)
            cmp({10'h0, pix_rgb}, pq.pop_front());
         // Fourth luma byte of each word: three pixel steps into the first or second line
         if (luma_valid && luma_ready && aq.size() > 0)
            cmp({2'h0, fetch_addr}, aq.pop_front());
      end
   end
   initial begin
      lw = $urandom(32'hE34CBA03);
      cw = $urandom;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      xfer(1, 8'h2C, 32'h007F_7F07, RESP_OKAY);
      xfer(1, 8'h00, 32'h0000_000C, RESP_OKAY);
      xfer(1, 8'h3C, 32'h0000_0001, RESP_SLVERR);
      xfer(0, 8'h2C, 32'h007F_7F07, RESP_OKAY);
      xfer(0, 8'h3C, 32'h0000_0000, RESP_SLVERR);
      @(negedge clock);
      cmp({8'h0, layer_order, cursor_cfg, resize_active}, {8'h0, LAYER_CURSOR,
         LAYER_VIDEO, LAYER_OVERLAY_LAYER_ONE, LAYER_BASE, 3'h6, 7'h7F, 7'h7F, 1'b1});
      xfer(1, 8'h10, 32'h0001_0003, RESP_OKAY);
      xfer(1, 8'h14, 32'h0003_0007, RESP_OKAY);
      // Ratios are 1024*(3+1)/(7+1) and 1024*(1+1)/(3+1)
      xfer(1, 8'h18, 32'h0200_0200, RESP_OKAY);
      xfer(0, 8'h18, 32'h0200_0200, RESP_OKAY);
      xfer(1, 8'h0C, 32'h0000_1000, RESP_OKAY);
      xfer(1, 8'h08, 32'hFFFF_FFFE, RESP_OKAY);
      xfer(1, 8'h04, 32'hFFFF_FFF0, RESP_OKAY);
      xfer(1, 8'h1C, 32'h0000_0010, RESP_OKAY);
      xfer(1, 8'h20, 32'h0000_0080, RESP_OKAY);
      xfer(1, 8'h24, 32'h0002_0000, RESP_OKAY);
      xfer(1, 8'h28, 32'h0800_0000, RESP_OKAY);
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 32; k++) begin
            y = lw[8*k[1:0] +: 8];
            sb = k[1:0] == 1 ? cw[15:8] + cw[31:24]
               : {k[1:0] == 0 ? cw[15:8] : cw[31:24], 1'b0};
            sr = k[1:0] == 1 ? cw[7:0] + cw[23:16]
               : {k[1:0] == 0 ? cw[7:0] : cw[23:16], 1'b0};
            pq.push_back({10'h0, y < 8'h10 ? 8'h0 : y - 8'h10,
                          sb[8:1], sr[8:1]});
            // Step is 1-2 per pixel, -16 per line end; frames reload base
            if (k[1:0] == 3)
               aq.push_back({2'h0, k[2] ? 32'h0000_0FE9 : 32'h0000_0FFD});
         end
         // One chroma line in 4:2:0 repeats, so both modes expect alike
         xfer(1, 8'h00, 32'(m * 2 + 1), RESP_OKAY);
         @(negedge clock);
         cmp({8'h0, layer_order, cursor_cfg, resize_active}, {8'h0,
            LAYER_CURSOR, LAYER_OVERLAY_LAYER_ONE, LAYER_VIDEO, LAYER_BASE, 3'h6, 7'h7F,
            7'h7F, 1'b0});
         while (pq.size() > 0) @(posedge clock);
         xfer(1, 8'h00, 32'h0000_0000, RESP_OKAY);
         // The open line drains to idle before the mode changes
         repeat (100) @(posedge clock);
      end
      close_out();
   end
endmodule : testbench
